// [include/omc_pkg.sv]
/*
 Package for the operating mode controller: mode states, command classes,
 reset vector location and bit timing constants.
 Assumes a single bus clock domain; the debug command decoder lives elsewhere.
*/
package omc_pkg;
    localparam logic [15:0] RESET_VECTOR_HI   = 16'hfffe;
    localparam logic [15:0] RESET_VECTOR_LO   = 16'hffff;
    localparam int          BIT_CELL_CYCLES   = 16;

    typedef enum logic [3:0] {
        CMD_MEM_ACCESS,
        CMD_MEM_STATUS,
        CMD_DEBUG_REG,
        CMD_HALT,
        CMD_CPU_REG,
        CMD_STEP,
        CMD_RESUME,
        CMD_NONE
    } omc_cmd_e;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_VEC_HI,
        ST_VEC_LO,
        ST_RUN,
        ST_BACKGROUND,
        ST_STEP
    } omc_state_e;

    typedef struct packed {
        logic     valid;
        omc_cmd_e cmd;
    } omc_cmd_s;
endpackage : omc_pkg

// [logic/omc_top.sv]
/*
 Operating mode controller: selects run or background mode at reset release,
 sequences reset vector fetch, halts on debug triggers and gates commands.
 Assumes an external decoder delivers one-cycle command strobes on CLK_IN,
 and the CPU acknowledges a vector byte read and a single step.
*/
module omc_top #(
    parameter int BIT_CELL_CYCLES = omc_pkg::BIT_CELL_CYCLES
) (
    input  wire logic                 CLK_IN,
    input  wire logic                 RESET_IN,
    input  wire logic                 POWER_ON_RESET_IN,
    input  wire logic                 FORCE_DEBUG_RESET_IN,
    input  wire logic                 MODE_PIN_IN,
    input  wire logic                 CMD_VALID_IN,
    input  wire omc_pkg::omc_cmd_e    CMD_IN,
    input  wire logic                 BG_ENTRY_INSTR_IN,
    input  wire logic                 CTRL_BREAK_IN,
    input  wire logic                 MODULE_BREAK_IN,
    input  wire logic                 MEM_ACK_IN,
    input  wire logic [7:0]           MEM_DATA_IN,
    input  wire logic                 STEP_DONE_IN,
    output logic                      MEM_READ_OUT,
    output logic [15:0]               MEM_ADDR_OUT,
    output logic [15:0]               START_PC_OUT,
    output logic                      PC_LOAD_OUT,
    output logic                      CPU_RUN_OUT,
    output logic                      BACKGROUND_OUT,
    output logic                      CMD_EXEC_OUT,
    output omc_pkg::omc_cmd_e         CMD_EXEC_CODE_OUT,
    output logic                      CMD_DROP_OUT,
    output logic                      PIN_IS_DEBUG_OUT,
    output logic                      BIT_TICK_OUT
);
    // Counter sized from the cell length so a retimed link needs no edit here
    localparam int               CNT_W    = (BIT_CELL_CYCLES > 1) ? $clog2(BIT_CELL_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BIT_CELL_CYCLES - 1);

    omc_pkg::omc_state_e state_q;
    logic                pin_meta_q;
    logic                pin_sync_q;
    logic                mode_latch_q;
    logic                in_reset_q;
    logic                sel_reset_q;
    logic [7:0]          vec_hi_q;
    logic [CNT_W-1:0]    bit_cnt_q;
    logic                bg_cmd;
    logic                intrusive;
    logic                halt_req;
    omc_pkg::omc_cmd_s   cmd_in;

    // Mode pin is asynchronous to the bus clock
    always_ff @(posedge CLK_IN) begin
        pin_meta_q <= MODE_PIN_IN;
        pin_sync_q <= pin_meta_q;
    end

    // Pin sampled continuously while reset holds; last value wins at release
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            in_reset_q   <= 1'b1;
            // Plain resets never select background, whatever the pin says
            sel_reset_q  <= POWER_ON_RESET_IN | FORCE_DEBUG_RESET_IN;
            mode_latch_q <= pin_sync_q;
        end else begin
            in_reset_q <= 1'b0;
        end
    end

    // Strobe and code travel as one word for the halt and gating decodes; the state machine reads the raw pins
    assign cmd_in    = '{valid: CMD_VALID_IN, cmd: CMD_IN};
    assign intrusive = (cmd_in.cmd == omc_pkg::CMD_CPU_REG) ||
                       (cmd_in.cmd == omc_pkg::CMD_STEP) ||
                       (cmd_in.cmd == omc_pkg::CMD_RESUME);
    assign bg_cmd    = cmd_in.valid && intrusive;
    // Any one trigger is enough to halt
    assign halt_req  = (cmd_in.valid && cmd_in.cmd == omc_pkg::CMD_HALT)
                       || BG_ENTRY_INSTR_IN
                       || CTRL_BREAK_IN || MODULE_BREAK_IN;

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_q <= omc_pkg::ST_RESET;
        end else begin
            unique case (state_q)
                omc_pkg::ST_RESET: begin
                    // Only qualified resets may choose background; others run
                    if (sel_reset_q && !mode_latch_q) begin
                        state_q <= omc_pkg::ST_BACKGROUND;
                    end else begin
                        state_q <= omc_pkg::ST_VEC_HI;
                    end
                end
                // Halt triggers are ignored until the start address is loaded
                omc_pkg::ST_VEC_HI: begin
                    if (MEM_ACK_IN) begin
                        state_q <= omc_pkg::ST_VEC_LO;
                    end
                end
                omc_pkg::ST_VEC_LO: begin
                    if (MEM_ACK_IN) begin
                        state_q <= omc_pkg::ST_RUN;
                    end
                end
                omc_pkg::ST_RUN: begin
                    if (halt_req) begin
                        state_q <= omc_pkg::ST_BACKGROUND;
                    end
                end
                omc_pkg::ST_BACKGROUND: begin
                    if (CMD_VALID_IN && CMD_IN == omc_pkg::CMD_RESUME) begin
                        state_q <= omc_pkg::ST_RUN;
                    end else if (CMD_VALID_IN && CMD_IN == omc_pkg::CMD_STEP) begin
                        state_q <= omc_pkg::ST_STEP;
                    end
                end
                // A halt during a step is moot: the step returns here anyway
                omc_pkg::ST_STEP: begin
                    if (STEP_DONE_IN) begin
                        state_q <= omc_pkg::ST_BACKGROUND;
                    end
                end
                default: begin
                    state_q <= omc_pkg::ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            vec_hi_q     <= 8'h00;
            START_PC_OUT <= 16'h0000;
            PC_LOAD_OUT  <= 1'b0;
        end else begin
            PC_LOAD_OUT <= 1'b0;
            if (state_q == omc_pkg::ST_VEC_HI && MEM_ACK_IN) begin
                vec_hi_q <= MEM_DATA_IN;
            end
            // High byte arrives first; the low byte completes the address
            if (state_q == omc_pkg::ST_VEC_LO && MEM_ACK_IN) begin
                START_PC_OUT <= {vec_hi_q, MEM_DATA_IN};
                PC_LOAD_OUT  <= 1'b1;
            end
        end
    end

    // Request held until acknowledged; address follows the fetch phase
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            MEM_READ_OUT <= 1'b0;
            MEM_ADDR_OUT <= 16'h0000;
        end else begin
            MEM_READ_OUT <= 1'b0;
            if (state_q == omc_pkg::ST_RESET && !(sel_reset_q && !mode_latch_q)) begin
                MEM_READ_OUT <= 1'b1;
                MEM_ADDR_OUT <= omc_pkg::RESET_VECTOR_HI;
            end else if (state_q == omc_pkg::ST_VEC_HI) begin
                MEM_READ_OUT <= 1'b1;
                MEM_ADDR_OUT <= MEM_ACK_IN ? omc_pkg::RESET_VECTOR_LO
                                           : omc_pkg::RESET_VECTOR_HI;
            end else if (state_q == omc_pkg::ST_VEC_LO && !MEM_ACK_IN) begin
                MEM_READ_OUT <= 1'b1;
                MEM_ADDR_OUT <= omc_pkg::RESET_VECTOR_LO;
            end
        end
    end

    // Run output also covers the single user instruction of a step
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            CPU_RUN_OUT      <= 1'b0;
            BACKGROUND_OUT   <= 1'b0;
            PIN_IS_DEBUG_OUT <= 1'b0;
        end else begin
            // Both flags switch on the halting edge so they never overlap
            CPU_RUN_OUT      <= (state_q == omc_pkg::ST_RUN && !halt_req)
                                || state_q == omc_pkg::ST_STEP;
            BACKGROUND_OUT   <= (state_q == omc_pkg::ST_BACKGROUND) ||
                                (state_q == omc_pkg::ST_RUN && halt_req);
            PIN_IS_DEBUG_OUT <= 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            CMD_EXEC_OUT      <= 1'b0;
            CMD_EXEC_CODE_OUT <= omc_pkg::CMD_NONE;
            CMD_DROP_OUT      <= 1'b0;
        end else begin
            CMD_EXEC_OUT      <= 1'b0;
            CMD_DROP_OUT      <= 1'b0;
            CMD_EXEC_CODE_OUT <= cmd_in.cmd;
            // Nothing is taken before the mode decision has been made
            if (cmd_in.valid && !in_reset_q && state_q != omc_pkg::ST_RESET) begin
                if (!intrusive) begin
                    CMD_EXEC_OUT <= 1'b1;
                end else if (state_q == omc_pkg::ST_BACKGROUND) begin
                    CMD_EXEC_OUT <= 1'b1;
                end else begin
                    CMD_DROP_OUT <= bg_cmd;
                end
            end
        end
    end

    // Bit cell timer for the serial engine
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            bit_cnt_q    <= '0;
            BIT_TICK_OUT <= 1'b0;
        end else begin
            // Explicit wrap so a cell length that is no power of two still works
            if (bit_cnt_q == CNT_LAST) begin
                bit_cnt_q <= '0;
            end else begin
                bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            end
            BIT_TICK_OUT <= (bit_cnt_q == CNT_LAST);
        end
    end
endmodule : omc_top

// [testbench/omc_mem_model.sv]
/* Vector memory partner: answers byte reads after wait_in cycles.
 Assumes the request holds until acknowledged. */
module omc_mem_model (
    input  wire logic        CLK_IN,
    input  wire logic        MEM_READ_OUT,
    input  wire logic [15:0] MEM_ADDR_OUT,
    input  wire logic [15:0] vec_in,
    input  wire logic [1:0]  wait_in,
    output logic             MEM_ACK_IN,
    output logic [7:0]       MEM_DATA_IN
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_q = 2'h0;
    logic       go;
    initial MEM_ACK_IN = 1'b0;
    initial MEM_DATA_IN = 8'h5a;
    assign go = MEM_READ_OUT && !MEM_ACK_IN && cnt_q == wait_in;
    always @(posedge CLK_IN) begin
        cnt_q <= (MEM_READ_OUT && !go && !MEM_ACK_IN) ? cnt_q + 2'h1 : 2'h0;
        MEM_ACK_IN <= go;
        // Data toggles when idle so a stale byte never looks valid
        MEM_DATA_IN <= go ? (MEM_ADDR_OUT[0] ? vec_in[7:0] : vec_in[15:8]) : ~MEM_DATA_IN;
    end
endmodule : omc_mem_model

// [testbench/omc_properties.sv]
/* Mode controller checker, bound to the top.
 Assumes one clock and a synchronous high reset. */
module omc_properties (
    input wire logic              CLK_IN,
    input wire logic              RESET_IN,
    input wire logic              CMD_VALID_IN,
    input wire omc_pkg::omc_cmd_e CMD_IN,
    input wire logic              BG_ENTRY_INSTR_IN,
    input wire logic              CTRL_BREAK_IN,
    input wire logic              MODULE_BREAK_IN,
    input wire logic              MEM_ACK_IN,
    input wire logic              MEM_READ_OUT,
    input wire logic [15:0]       MEM_ADDR_OUT,
    input wire logic              PC_LOAD_OUT,
    input wire logic              CPU_RUN_OUT,
    input wire logic              BACKGROUND_OUT,
    input wire logic              CMD_EXEC_OUT,
    input wire omc_pkg::omc_cmd_e CMD_EXEC_CODE_OUT,
    input wire logic              CMD_DROP_OUT,
    input wire logic              PIN_IS_DEBUG_OUT,
    input wire logic              BIT_TICK_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence s_load;
        PC_LOAD_OUT ##1 CPU_RUN_OUT;
    endsequence
    property p_vec;
        MEM_ACK_IN && MEM_READ_OUT && MEM_ADDR_OUT == 16'hffff |-> ##[1:2] s_load;
    endproperty
    property p_drop;
        CPU_RUN_OUT && CMD_VALID_IN && CMD_IN inside {omc_pkg::CMD_CPU_REG,
            omc_pkg::CMD_STEP, omc_pkg::CMD_RESUME} |=> CMD_DROP_OUT && !CMD_EXEC_OUT;
    endproperty
    property p_nonint;
        (CPU_RUN_OUT || BACKGROUND_OUT) && CMD_VALID_IN && CMD_IN <= omc_pkg::CMD_HALT
            |=> CMD_EXEC_OUT && CMD_EXEC_CODE_OUT == $past(CMD_IN);
    endproperty
    property p_halt;
        CPU_RUN_OUT && CMD_VALID_IN && CMD_IN == omc_pkg::CMD_HALT
            |=> BACKGROUND_OUT && !CPU_RUN_OUT;
    endproperty
    property p_trig;
        CPU_RUN_OUT && (BG_ENTRY_INSTR_IN || CTRL_BREAK_IN || MODULE_BREAK_IN)
            |=> BACKGROUND_OUT;
    endproperty
    property p_excl;
        !(CPU_RUN_OUT && BACKGROUND_OUT);
    endproperty
    property p_resume;
        BACKGROUND_OUT && CMD_VALID_IN && CMD_IN == omc_pkg::CMD_RESUME
            |=> CMD_EXEC_OUT ##[0:2] CPU_RUN_OUT;
    endproperty
    property p_pin;
        $fell(RESET_IN) |-> ##[0:2] PIN_IS_DEBUG_OUT;
    endproperty
    property p_pin_rst;
        disable iff (1'b0) RESET_IN |=> !PIN_IS_DEBUG_OUT;
    endproperty
    sequence s_cell_gap;
        !BIT_TICK_OUT [*8] ##1 !BIT_TICK_OUT [*7];
    endsequence
    property p_tick;
        BIT_TICK_OUT |=> s_cell_gap ##1 BIT_TICK_OUT;
    endproperty
    a_vec: assert property (p_vec) else $error("no run after vector");
    a_drop: assert property (p_drop) else $error("command not dropped");
    a_nonint: assert property (p_nonint) else $error("command not run");
    a_halt: assert property (p_halt) else $error("halt ignored");
    a_trig: assert property (p_trig) else $error("trigger ignored");
    a_excl: assert property (p_excl) else $error("run in background");
    a_resume: assert property (p_resume) else $error("resume failed");
    a_pin: assert property (p_pin) else $error("pin not debug");
    a_pin_rst: assert property (p_pin_rst) else $error("pin not mode select");
    a_tick: assert property (p_tick) else $error("bit cell length");
endmodule : omc_properties
bind omc_top omc_properties i_prop (.*);

// [testbench/test_operating_mode_control.sv]
/* Self-checking bench for the mode controller.
 Assumes the vector memory partner and the bound checker. */
module test_operating_mode_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK_IN = 0, RESET_IN = 1, POWER_ON_RESET_IN = 0, FORCE_DEBUG_RESET_IN = 0;
    logic MODE_PIN_IN = 1, CMD_VALID_IN = 0, BG_ENTRY_INSTR_IN = 0, CTRL_BREAK_IN = 0;
    logic MODULE_BREAK_IN = 0, STEP_DONE_IN = 0, MEM_ACK_IN, MEM_READ_OUT, PC_LOAD_OUT;
    logic CPU_RUN_OUT, BACKGROUND_OUT, CMD_EXEC_OUT, CMD_DROP_OUT, PIN_IS_DEBUG_OUT;
    logic BIT_TICK_OUT;
    logic [7:0] MEM_DATA_IN;
    logic [15:0] MEM_ADDR_OUT, START_PC_OUT, vec = 16'h0;
    logic [1:0] wt = 2'h0;
    omc_pkg::omc_cmd_e CMD_IN = omc_pkg::CMD_NONE, CMD_EXEC_CODE_OUT;
    int n_fail = 0, check_count = 0, seed = 32'hb511;
    logic [4:0] exp_q[$];
    logic [4:0] e;
    always #12.5 CLK_IN = ~CLK_IN;
    omc_top i_dut (.*);
    omc_mem_model i_mem (.vec_in(vec), .wait_in(wt), .*);
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_IN);
        #2;
    endtask : tick
    task automatic send(input omc_pkg::omc_cmd_e c, input logic drop);
        tick(1);
        CMD_VALID_IN = 1;
        CMD_IN = c;
        exp_q.push_back({drop, c});
        tick(1);
        CMD_VALID_IN = 0;
        tick(2);
    endtask : send
    // Results are matched in order as they appear
    always @(posedge CLK_IN) begin
        #1;
        if (CMD_EXEC_OUT === 1'b1 || CMD_DROP_OUT === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "unexpected result");
            end else begin
                e = exp_q.pop_front();
                chk(CMD_DROP_OUT === e[4] && CMD_EXEC_OUT === ~e[4]
                    && (e[4] || CMD_EXEC_CODE_OUT === e[3:0]), "cmd");
            end
        end
    end
    task automatic rb(input logic p, f, m, bg);
        RESET_IN = 1;
        POWER_ON_RESET_IN = p;
        FORCE_DEBUG_RESET_IN = f;
        MODE_PIN_IN = m;
        vec = 16'($random(seed));
        wt = 2'($random(seed));
        tick(10);
        RESET_IN = 0;
        POWER_ON_RESET_IN = 0;
        FORCE_DEBUG_RESET_IN = 0;
        tick(3);
        MODE_PIN_IN = 1;
        chk(PIN_IS_DEBUG_OUT === 1'b1, "pin role");
        if (bg) begin
            chk(BACKGROUND_OUT === 1'b1 && CPU_RUN_OUT === 1'b0, "reset bg");
        end else begin
            for (int i = 0; i < 30 && PC_LOAD_OUT !== 1'b1; i++) tick(1);
            chk(START_PC_OUT === vec, "start address");
            tick(2);
            chk(CPU_RUN_OUT === 1'b1 && BACKGROUND_OUT === 1'b0, "run mode");
        end
    endtask : rb
    task automatic summarize();
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    initial begin
        #(25 * 5000);
        n_fail++;
        summarize();
    end
    initial begin
        rb(0, 0, 1, 0);
        for (int k = 4; k < 7; k++) send(omc_pkg::omc_cmd_e'(k), 1);
        for (int k = 0; k < 3; k++) send(omc_pkg::omc_cmd_e'(k), 0);
        send(omc_pkg::CMD_HALT, 0);
        chk(BACKGROUND_OUT === 1'b1 && CPU_RUN_OUT === 1'b0, "halt");
        send(omc_pkg::CMD_CPU_REG, 0);
        send(omc_pkg::CMD_MEM_STATUS, 0);
        send(omc_pkg::CMD_STEP, 0);
        STEP_DONE_IN = 1;
        tick(1);
        STEP_DONE_IN = 0;
        tick(2);
        chk(BACKGROUND_OUT === 1'b1, "step back");
        for (int k = 0; k < 3; k++) begin
            send(omc_pkg::CMD_RESUME, 0);
            chk(CPU_RUN_OUT === 1'b1, "resume");
            {BG_ENTRY_INSTR_IN, CTRL_BREAK_IN, MODULE_BREAK_IN} = 3'h4 >> k;
            tick(1);
            {BG_ENTRY_INSTR_IN, CTRL_BREAK_IN, MODULE_BREAK_IN} = 3'h0;
            tick(2);
            chk(BACKGROUND_OUT === 1'b1 && CPU_RUN_OUT === 1'b0, "trigger");
        end
        rb(1, 0, 0, 1);
        rb(0, 1, 0, 1);
        rb(0, 0, 0, 0);
        rb(1, 0, 1, 0);
        chk(exp_q.size() == 0, "missing result");
        summarize();
    end
endmodule : test_operating_mode_control
